// file: core/cod_consts.vh
/*
 opcode decoder constants: opcodes, operation codes, addressing modes,
 bus cycle kinds, lengths and base cycle counts.
 assumes inclusion by the decoder files only.
*/
`ifndef COD_CONSTS_VH
`define COD_CONSTS_VH

`define COD_OPC_BIT0_LOW_BR 8'h01
`define COD_OPC_CLEAR_BIT0 8'h11
`define COD_OPC_NEVER_BR 8'h21
`define COD_OPC_COMPARE_BR_DIRECT 8'h31
`define COD_OPC_COMPARE_BR_ACC 8'h41
`define COD_OPC_COMPARE_BR_XLOW 8'h51
`define COD_OPC_COMPARE_BR_IDX_PINC 8'h61
`define COD_OPC_SIGNED_BELOW_BR 8'h91
`define COD_OPC_ACCMEM_DIRECT 8'hb1
`define COD_OPC_ACCMEM_FULL 8'hc1
`define COD_OPC_ACCMEM_IDX_WORD 8'hd1
`define COD_OPC_WAIT_IRQ 8'h8f

`define COD_OP_UNKNOWN 4'h0
`define COD_OP_BR_BIT0_LOW 4'h1
`define COD_OP_CLEAR_BIT0 4'h2
`define COD_OP_BR_NEVER 4'h3
`define COD_OP_COMPARE_BR_EQ 4'h4
`define COD_OP_COMPARE_ACC_BR_EQ 4'h5
`define COD_OP_COMPARE_XLO_BR_EQ 4'h6
`define COD_OP_BR_SIGNED_BELOW 4'h7
`define COD_OP_ACC_VS_MEM 4'h8
`define COD_OP_WAIT_IRQ 4'h9

`define COD_MODE_NONE 4'h0
`define COD_MODE_DIRECT 4'h1
`define COD_MODE_FULL_ADDR 4'h2
`define COD_MODE_LITERAL 4'h3
`define COD_MODE_IMPLIED 4'h4
`define COD_MODE_IDX_BYTE 4'h5
`define COD_MODE_IDX_WORD 4'h6
`define COD_MODE_IDX_BYTE_PINC 4'h7
`define COD_MODE_PC_OFFSET 4'h8

`define COD_CYC_FREE 3'h0
`define COD_CYC_FETCH 3'h1
`define COD_CYC_RD 3'h2
`define COD_CYC_WR 3'h3
`define COD_CYC_PUSH 3'h4
`define COD_CYC_POP 3'h5
`define COD_CYC_VEC 3'h6

`define COD_LEN_1 2'h1
`define COD_LEN_2 2'h2
`define COD_LEN_3 2'h3
`define COD_CNT_2 4'h2
`define COD_CNT_3 4'h3
`define COD_CNT_4 4'h4
`define COD_CNT_5 4'h5
`define COD_VEC_PAGE 8'hff
`define COD_RST_PC 16'h0000
`define COD_RST_ADDR 16'h0000
`define COD_RST_DATA 8'h00
`define COD_RST_LEN 2'h0
`define COD_RST_CYC 4'h0

`define COD_F_OP_HI 13
`define COD_F_OP_LO 10
`define COD_F_LEN_HI 9
`define COD_F_LEN_LO 8
`define COD_F_MODE_HI 7
`define COD_F_MODE_LO 4
`define COD_F_CYC_HI 3
`define COD_F_CYC_LO 0

`endif

// file: core/cod_busgen.v
/*
 bus cycle generator: turns a cycle kind into one bus access.
 assumes clk is the bus clock and requests arrive on that clock.
*/
`timescale 1ns/1ns
`include "cod_consts.vh"
module cod_busgen (
    // clock and reset
    input wire clk,
    input wire resetn,
    // request
    input wire req,
    input wire [2:0] kind,
    input wire [15:0] opnd_addr,
    input wire [15:0] sp,
    input wire [7:0] vec_low_addr,
    input wire [7:0] wdata,
    input wire vec_second,
    // bus
    output reg [15:0] addr_q,
    output reg rd_q,
    output reg wr_q,
    output reg [7:0] wdata_q,
    output reg [15:0] pc_q
);
    always @(posedge clk) begin
        if (!resetn) begin
            addr_q <= `COD_RST_ADDR;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= `COD_RST_DATA;
            pc_q <= `COD_RST_PC;
        end else begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            if (req) begin
                case (kind)
                    `COD_CYC_FREE: begin
                        rd_q <= 1'b1;
                        addr_q <= pc_q;
                    end
                    `COD_CYC_FETCH: begin
                        rd_q <= 1'b1;
                        addr_q <= pc_q;
                        pc_q <= pc_q + 16'h0001;
                    end
                    `COD_CYC_RD: begin
                        rd_q <= 1'b1;
                        addr_q <= opnd_addr;
                    end
                    `COD_CYC_WR: begin
                        wr_q <= 1'b1;
                        addr_q <= opnd_addr;
                        wdata_q <= wdata;
                    end
                    `COD_CYC_PUSH: begin
                        wr_q <= 1'b1;
                        addr_q <= sp;
                        wdata_q <= wdata;
                    end
                    `COD_CYC_POP: begin
                        rd_q <= 1'b1;
                        addr_q <= sp + 16'h0001;
                    end
                    `COD_CYC_VEC: begin
                        rd_q <= 1'b1;
                        addr_q <= {`COD_VEC_PAGE,
                                   vec_low_addr[7:1], vec_second};
                    end
                    default: begin
                        rd_q <= 1'b1;
                        addr_q <= pc_q;
                    end
                endcase
            end
        end
    end
endmodule

// file: core/cod_decoder.v
/*
 opcode decoder slice of the core: for each listed opcode it gives the
 operation, the length in bytes, the addressing mode and the base cycle
 count, all registered, plus a held halt flag and a one-cycle mask
 clear pulse for the wait opcode. it also holds the bus cycle generator
 that turns one requested cycle kind into one system bus access.
 assumes opcodes and cycle requests come from the fetch sequencer on
 clk, at most one of each per clock; bus answers are not seen here.
 halting on the wait opcode is left to the sequencer, which only sees
 the flag; unknown opcodes give all zero fields with the known flag low
 so that the sequencer can trap them.
*/
`timescale 1ns/1ns
`include "cod_consts.vh"
module cod_decoder (
    // clock and reset
    input wire clk,
    input wire resetn,
    // opcode in
    input wire opc_valid,
    input wire [7:0] opcode,
    // decode out
    output reg dec_valid_q,
    output reg [3:0] dec_op_q,
    output reg [1:0] dec_len_q,
    output reg [3:0] dec_mode_q,
    output reg [3:0] dec_cycles_q,
    output reg dec_known_q,
    output reg dec_wait_q,
    output reg dec_clr_imask_q,
    // bus cycle request
    input wire cyc_req,
    input wire [2:0] cyc_kind,
    input wire [15:0] cyc_addr,
    input wire [15:0] cyc_sp,
    input wire [7:0] cyc_vec,
    input wire [7:0] cyc_wdata,
    input wire cyc_vec_second,
    // system bus
    output wire [15:0] bus_addr,
    output wire bus_rd,
    output wire bus_wr,
    output wire [7:0] bus_wdata,
    output wire [15:0] fetch_pc
);
    // packed {op, len, mode, cycles}; unknown opcodes give all zero so
    // the sequencer can trap them
    function [13:0] dec_fn;
        input [7:0] o;
        reg [3:0] op;
        reg [1:0] ln;
        reg [3:0] md;
        reg [3:0] cy;
        begin
            op = `COD_OP_UNKNOWN;
            ln = `COD_RST_LEN;
            md = `COD_MODE_NONE;
            cy = `COD_RST_CYC;
            case (o)
                `COD_OPC_BIT0_LOW_BR: begin
                    op = `COD_OP_BR_BIT0_LOW;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_DIRECT;
                    cy = `COD_CNT_5;
                end
                `COD_OPC_CLEAR_BIT0: begin
                    op = `COD_OP_CLEAR_BIT0;
                    ln = `COD_LEN_2;
                    md = `COD_MODE_DIRECT;
                    cy = `COD_CNT_5;
                end
                `COD_OPC_NEVER_BR: begin
                    op = `COD_OP_BR_NEVER;
                    ln = `COD_LEN_2;
                    md = `COD_MODE_PC_OFFSET;
                    cy = `COD_CNT_3;
                end
                `COD_OPC_COMPARE_BR_DIRECT: begin
                    op = `COD_OP_COMPARE_BR_EQ;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_DIRECT;
                    cy = `COD_CNT_5;
                end
                `COD_OPC_COMPARE_BR_ACC: begin
                    op = `COD_OP_COMPARE_ACC_BR_EQ;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_LITERAL;
                    cy = `COD_CNT_4;
                end
                `COD_OPC_COMPARE_BR_XLOW: begin
                    op = `COD_OP_COMPARE_XLO_BR_EQ;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_LITERAL;
                    cy = `COD_CNT_4;
                end
                `COD_OPC_COMPARE_BR_IDX_PINC: begin
                    op = `COD_OP_COMPARE_BR_EQ;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_IDX_BYTE_PINC;
                    cy = `COD_CNT_5;
                end
                `COD_OPC_SIGNED_BELOW_BR: begin
                    op = `COD_OP_BR_SIGNED_BELOW;
                    ln = `COD_LEN_2;
                    md = `COD_MODE_PC_OFFSET;
                    cy = `COD_CNT_3;
                end
                `COD_OPC_ACCMEM_DIRECT: begin
                    op = `COD_OP_ACC_VS_MEM;
                    ln = `COD_LEN_2;
                    md = `COD_MODE_DIRECT;
                    cy = `COD_CNT_3;
                end
                `COD_OPC_ACCMEM_FULL: begin
                    op = `COD_OP_ACC_VS_MEM;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_FULL_ADDR;
                    cy = `COD_CNT_4;
                end
                `COD_OPC_ACCMEM_IDX_WORD: begin
                    op = `COD_OP_ACC_VS_MEM;
                    ln = `COD_LEN_3;
                    md = `COD_MODE_IDX_WORD;
                    cy = `COD_CNT_4;
                end
                `COD_OPC_WAIT_IRQ: begin
                    op = `COD_OP_WAIT_IRQ;
                    ln = `COD_LEN_1;
                    md = `COD_MODE_IMPLIED;
                    cy = `COD_CNT_2;
                end
                default: begin
                    op = `COD_OP_UNKNOWN;
                    ln = `COD_RST_LEN;
                    md = `COD_MODE_NONE;
                    cy = `COD_RST_CYC;
                end
            endcase
            dec_fn = {op, ln, md, cy};
        end
    endfunction

    wire [13:0] dec_w;
    wire [3:0] dec_op_w;
    wire [1:0] dec_len_w;
    wire [3:0] dec_mode_w;
    wire [3:0] dec_cycles_w;
    wire dec_is_wait_w;

    assign dec_w = dec_fn(opcode);
    // field positions live in the header so the packing stays in one place
    assign dec_op_w = dec_w[`COD_F_OP_HI:`COD_F_OP_LO];
    assign dec_len_w = dec_w[`COD_F_LEN_HI:`COD_F_LEN_LO];
    assign dec_mode_w = dec_w[`COD_F_MODE_HI:`COD_F_MODE_LO];
    assign dec_cycles_w = dec_w[`COD_F_CYC_HI:`COD_F_CYC_LO];
    assign dec_is_wait_w = (dec_op_w == `COD_OP_WAIT_IRQ);

    // strobes last one cycle
    // a held mask clear would fire again on every later cycle
    always @(posedge clk) begin
        if (!resetn) begin
            dec_valid_q <= 1'b0;
            dec_clr_imask_q <= 1'b0;
        end else begin
            dec_valid_q <= opc_valid;
            dec_clr_imask_q <= opc_valid && dec_is_wait_w;
        end
    end

    // fields hold until next opcode
    // holding, not clearing, lets the sequencer read them at leisure
    always @(posedge clk) begin
        if (!resetn) begin
            dec_op_q <= `COD_OP_UNKNOWN;
            dec_len_q <= `COD_RST_LEN;
            dec_mode_q <= `COD_MODE_NONE;
            dec_cycles_q <= `COD_RST_CYC;
            dec_known_q <= 1'b0;
            dec_wait_q <= 1'b0;
        end else if (opc_valid) begin
            dec_op_q <= dec_op_w;
            dec_len_q <= dec_len_w;
            dec_mode_q <= dec_mode_w;
            dec_cycles_q <= dec_cycles_w;
            dec_known_q <= (dec_op_w != `COD_OP_UNKNOWN);
            dec_wait_q <= dec_is_wait_w;
        end
    end

    // bus cycles share clk with the sequencer, so no crossing is needed
    cod_busgen i_cod_busgen (
        .clk(clk),
        .resetn(resetn),
        // request side
        .req(cyc_req),
        .kind(cyc_kind),
        .opnd_addr(cyc_addr),
        .sp(cyc_sp),
        .vec_low_addr(cyc_vec),
        .wdata(cyc_wdata),
        .vec_second(cyc_vec_second),
        // bus side
        .addr_q(bus_addr),
        .rd_q(bus_rd),
        .wr_q(bus_wr),
        .wdata_q(bus_wdata),
        .pc_q(fetch_pc)
    );
endmodule

// file: sim/cod_decoder_props.sv
/* port assertions for the opcode decoder.
 assumes binding to cod_decoder, one clock, synchronous reset. */
`timescale 1ns/1ns
module cod_decoder_chk (
    // clock and reset
    input wire clk,
    input wire resetn,
    // decode
    input wire opc_valid,
    input wire [7:0] opcode,
    input wire dec_valid_q,
    input wire [3:0] dec_op_q,
    input wire [1:0] dec_len_q,
    input wire [3:0] dec_cycles_q,
    input wire dec_wait_q,
    input wire dec_clr_imask_q,
    // bus
    input wire cyc_req,
    input wire [2:0] cyc_kind,
    input wire [15:0] cyc_sp,
    input wire cyc_vec_second,
    input wire [15:0] bus_addr,
    input wire bus_rd,
    input wire bus_wr,
    input wire [15:0] fetch_pc
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_dec_valid: assert property (1'b1 |=>
        dec_valid_q == $past(opc_valid))
        else $error("decode answer missing");
    chk_op41_fields: assert property (opc_valid && opcode == 8'h41 |=>
        dec_op_q == 4'h5 && dec_len_q == 2'h3 && dec_cycles_q == 4'h4)
        else $error("opcode 41 fields wrong");
    chk_op01_fields: assert property (opc_valid && opcode == 8'h01 |=>
        dec_op_q == 4'h1 && dec_len_q == 2'h3 && dec_cycles_q == 4'h5)
        else $error("opcode 01 fields wrong");
    chk_wait_flags: assert property (opc_valid && opcode == 8'h8f |=>
        dec_wait_q && dec_clr_imask_q && dec_cycles_q >= 4'h2)
        else $error("wait opcode flags wrong");
    chk_fetch_step: assert property (cyc_req && cyc_kind == 3'h1 |=>
        bus_rd && bus_addr == $past(fetch_pc) &&
        fetch_pc == $past(fetch_pc) + 16'h1)
        else $error("fetch not consecutive");
    chk_free_read: assert property (cyc_req && cyc_kind == 3'h0 |=>
        bus_rd && !bus_wr && $stable(fetch_pc) &&
        bus_addr == $past(fetch_pc) ##1 (!bus_rd || $past(cyc_req)))
        else $error("free cycle wrong");
    chk_push_write: assert property (cyc_req && cyc_kind == 3'h4 |=>
        bus_wr && !bus_rd && bus_addr == $past(cyc_sp))
        else $error("push not one write at sp");
    chk_vec_page: assert property (cyc_req && cyc_kind == 3'h6 |=>
        bus_rd && bus_addr[15:8] == 8'hff &&
        bus_addr[0] == $past(cyc_vec_second))
        else $error("vector read off top page");
    cover property (opc_valid && opcode == 8'h8f);
    cover property (cyc_req && cyc_kind == 3'h6);
    cover property (cyc_req && cyc_kind == 3'h5);
endmodule
bind cod_decoder cod_decoder_chk i_cod_decoder_chk (.clk, .resetn,
    .opc_valid, .opcode, .dec_valid_q, .dec_op_q, .dec_len_q, .dec_cycles_q,
    .dec_wait_q, .dec_clr_imask_q, .cyc_req, .cyc_kind, .cyc_sp,
    .cyc_vec_second, .bus_addr, .bus_rd, .bus_wr, .fetch_pc);

// file: sim/cod_mem_model.sv
/* small memory on the system bus, 16 bytes aliased.
 assumes strobes last one clk; undriven read data is not trusted. */
`timescale 1ns/1ns
module cod_mem_model (
    // clock
    input wire clk,
    // bus
    input wire [15:0] bus_addr,
    input wire bus_rd,
    input wire bus_wr,
    input wire [7:0] bus_wdata,
    output wire [7:0] rdata
);
    reg [7:0] mem [0:15];
    reg [7:0] last_q;
    // released data flips to the inverse of the last value every clk, so a stale value shows again every other cycle
    assign rdata = bus_rd ? mem[bus_addr[3:0]] : ~last_q;
    always @(posedge clk) begin
        if (bus_wr)
            mem[bus_addr[3:0]] <= bus_wdata;
        last_q <= rdata;
    end
endmodule

// file: sim/tb.sv
/* self-checking bench for the opcode decoder.
 assumes 100 ns clock and the memory model on the bus side. */
`timescale 1ns/1ns
module tb;
    reg clk, resetn, opc_valid, cyc_req, cyc_vec_second;
    reg [7:0] opcode, cyc_vec, cyc_wdata;
    reg [2:0] cyc_kind;
    reg [15:0] cyc_addr, cyc_sp;
    wire dec_valid_q, dec_known_q, dec_wait_q, dec_clr_imask_q;
    wire [3:0] dec_op_q, dec_mode_q, dec_cycles_q;
    wire [1:0] dec_len_q;
    wire [15:0] bus_addr, fetch_pc;
    wire bus_rd, bus_wr;
    wire [7:0] bus_wdata, rdata;
    integer fails = 0, compares = 0;
    cod_decoder i_cod_decoder (.clk, .resetn, .opc_valid, .opcode,
        .dec_valid_q, .dec_op_q, .dec_len_q, .dec_mode_q, .dec_cycles_q,
        .dec_known_q, .dec_wait_q, .dec_clr_imask_q, .cyc_req, .cyc_kind,
        .cyc_addr, .cyc_sp, .cyc_vec, .cyc_wdata, .cyc_vec_second,
        .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .fetch_pc);
    cod_mem_model i_cod_mem_model (.clk, .bus_addr, .bus_rd, .bus_wr,
        .bus_wdata, .rdata);
    always #50 clk = ~clk;
    task chk(input ok, input [8*8-1:0] m);
        compares = compares + 1;
        if (!ok) begin
            fails = fails + 1;
            $display("mismatch %0t %0s", $time, m);
        end
    endtask
    task dec(input [7:0] o, input [3:0] op, input [1:0] ln, input [3:0] md,
        input [3:0] cy);
        @(posedge clk) opc_valid <= 1'b1;
        opcode <= o;
        @(posedge clk) opc_valid <= 1'b0;
        #1 chk(dec_valid_q === 1'b1 && dec_op_q === op && dec_len_q === ln
            && dec_mode_q === md && dec_cycles_q === cy
            && dec_known_q === (op != 4'h0), "decode");
    endtask
    task bus(input [2:0] k, input s, input [15:0] ea, input er, input ew,
        input [15:0] ep);
        @(posedge clk) cyc_req <= 1'b1;
        cyc_kind <= k;
        cyc_vec_second <= s;
        @(posedge clk) cyc_req <= 1'b0;
        #1 chk(bus_addr === ea && bus_rd === er && bus_wr === ew
            && fetch_pc === ep, "bus");
    endtask
    task t_decode;
        dec(8'h01, 4'h1, 2'h3, 4'h1, 4'h5);
        dec(8'h11, 4'h2, 2'h2, 4'h1, 4'h5);
        dec(8'h21, 4'h3, 2'h2, 4'h8, 4'h3);
        dec(8'h31, 4'h4, 2'h3, 4'h1, 4'h5);
        dec(8'h41, 4'h5, 2'h3, 4'h3, 4'h4);
        dec(8'h51, 4'h6, 2'h3, 4'h3, 4'h4);
        dec(8'h61, 4'h4, 2'h3, 4'h7, 4'h5);
        dec(8'h91, 4'h7, 2'h2, 4'h8, 4'h3);
        dec(8'hb1, 4'h8, 2'h2, 4'h1, 4'h3);
        dec(8'hc1, 4'h8, 2'h3, 4'h2, 4'h4);
        dec(8'hd1, 4'h8, 2'h3, 4'h6, 4'h4);
        dec(8'h8f, 4'h9, 2'h1, 4'h4, 4'h2);
        chk(dec_wait_q === 1'b1 && dec_clr_imask_q === 1'b1, "wait");
        dec(8'h00, 4'h0, 2'h0, 4'h0, 4'h0);
        chk(dec_wait_q === 1'b0, "unwait");
        $display("test decode done");
    endtask
    task t_bus;
        bus(3'h1, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h0001);
        bus(3'h1, 1'b0, 16'h0001, 1'b1, 1'b0, 16'h0002);
        bus(3'h0, 1'b0, 16'h0002, 1'b1, 1'b0, 16'h0002);
        bus(3'h3, 1'b0, 16'h0040, 1'b0, 1'b1, 16'h0002);
        bus(3'h2, 1'b0, 16'h0040, 1'b1, 1'b0, 16'h0002);
        chk(rdata === 8'h5a, "rdback");
        // fresh data, so the pop proves it reads the pushed byte
        @(posedge clk) cyc_wdata <= 8'ha5;
        bus(3'h4, 1'b0, 16'h00f0, 1'b0, 1'b1, 16'h0002);
        chk(bus_wdata === 8'ha5, "push");
        @(posedge clk) cyc_sp <= 16'h00ef;
        bus(3'h5, 1'b0, 16'h00f0, 1'b1, 1'b0, 16'h0002);
        chk(rdata === 8'ha5, "pop");
        bus(3'h6, 1'b0, 16'hfffe, 1'b1, 1'b0, 16'h0002);
        bus(3'h6, 1'b1, 16'hffff, 1'b1, 1'b0, 16'h0002);
        $display("test bus done");
    endtask
    task t_reset;
        dec(8'h41, 4'h5, 2'h3, 4'h3, 4'h4);
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) resetn <= 1'b1;
        #1 chk(fetch_pc === 16'h0000 && bus_addr === 16'h0000
            && dec_op_q === 4'h0 && dec_valid_q === 1'b0, "reset");
        bus(3'h1, 1'b0, 16'h0000, 1'b1, 1'b0, 16'h0001);
        $display("test reset done");
    endtask
    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 0; resetn = 0; opc_valid = 0; cyc_req = 0; cyc_vec_second = 0;
        opcode = 8'h00; cyc_kind = 3'h0; cyc_vec = 8'hfe; cyc_wdata = 8'h5a;
        cyc_addr = 16'h0040; cyc_sp = 16'h00f0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_decode;
        t_bus;
        // second reset in mid-run must clear the fetch pointer
        t_reset;
        finish_test;
    end
    initial begin
        #100000 fails = fails + 1;
        finish_test;
    end
endmodule
